// [common/handler_pkg.sv]
package handler_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_TEST_OUT   = 4'h1;
    localparam logic [3:0] REG_TEST_CLASS = 4'h2;
    localparam logic [3:0] REG_TEST_COMP  = 4'h3;
    localparam logic [3:0] REG_STATUS     = 4'h4;
    localparam logic [3:0] REG_INPUTS     = 4'h5;
    localparam logic [3:0] REG_VOLT       = 4'h6;
    localparam logic [3:0] REG_INT_STAT   = 4'h7;
    localparam logic [3:0] REG_INT_EN     = 4'h8;
    localparam logic [3:0] REG_INT_CLR    = 4'h9;
    localparam logic [3:0] REG_MEAS_RES   = 4'ha;
    localparam logic [3:0] REG_RANGE      = 4'hb;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_TEST_BIT   = 0;
    localparam int CTRL_START_BIT  = 1;
    localparam int TO_FAULT_BIT    = 0;
    localparam int TO_ANALOG_BIT   = 1;
    localparam int TO_CYCLE_BIT    = 2;
    localparam int TO_ACCEPT_BIT   = 3;
    localparam int TO_OVER_BIT     = 4;
    localparam int TO_OPEN_BIT     = 5;
    localparam int IN_TRIG_BIT     = 0;
    localparam int IN_LOCK_BIT     = 1;
    localparam int IRQ_TRIG_BIT    = 0;
    localparam int IRQ_ANALOG_BIT  = 1;
    localparam int IRQ_CYCLE_BIT   = 2;
    localparam int IRQ_W           = 3;

    // ----------------------------------------
    // Reset values and thresholds
    // ----------------------------------------
    localparam logic [4:0] VOLT_RESET = 5'h05;
    localparam logic [4:0] VOLT_MID   = 5'h09;
    localparam logic [4:0] VOLT_HIGH  = 5'h0f;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ            = 20;
    localparam int TRIG_MIN_US        = 1;
    localparam int RESP_US            = 40;
    localparam int ANALOG_US          = 1300;
    localparam int COMPUTE_US         = 1000;
    localparam int TRIG_MIN_CYC       = TRIG_MIN_US * CLK_MHZ;
    localparam int RESP_CYC           = RESP_US * CLK_MHZ;
    localparam int ANALOG_CYC         = ANALOG_US * CLK_MHZ;
    localparam int COMPUTE_CYC        = COMPUTE_US * CLK_MHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RESP    = 3'b001,
        ST_ANALOG  = 3'b010,
        ST_COMPUTE = 3'b011,
        ST_DONE    = 3'b100
    } meas_state_t;

    typedef struct packed {
        logic       fault_n;
        logic       analog_done_n;
        logic       cycle_done_n;
        logic       trigger_accept_n;
        logic       overrange_n;
        logic       low_cap_or_open_n;
        logic [8:0] sort_class_n;
        logic       primary_above_n;
        logic       primary_below_n;
        logic       secondary_reject_n;
    } handler_out_t;

    typedef struct packed {
        logic       overrange;
        logic       low_cap;
        logic [3:0] sort_class;
        logic [2:0] comp;
    } meas_result_t;

endpackage : handler_pkg

// [rtl/input_sync.sv]
`timescale 1ns/1ns
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : input_sync

// [rtl/range_decode.sv]
`timescale 1ns/1ns
module range_decode
    import handler_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Voltage setting in volts
    input  wire logic [4:0] drive_volts,
    // Switch drives
    output logic            range_switch_low,
    output logic            range_switch_mid,
    output logic            range_switch_high
);
    logic [2:0] sw_q;
    logic [2:0] sw_d;

    // ----------------------------------------
    // One-hot decode
    // ----------------------------------------
    always_comb begin
        if (drive_volts < VOLT_MID) begin
            sw_d = 3'h1;
        end else if (drive_volts < VOLT_HIGH) begin
            sw_d = 3'h2;
        end else begin
            sw_d = 3'h4;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sw_q <= 3'h1;
        end else begin
            sw_q <= sw_d;
        end
    end

    assign range_switch_low  = sw_q[0];
    assign range_switch_mid  = sw_q[1];
    assign range_switch_high = sw_q[2];

    a_range_onehot: assert property (@(posedge mclk) disable iff (reset)
        $onehot(sw_q)) else $error("range switches not one-hot");
    a_range_high_sel: assert property (@(posedge mclk) disable iff (reset)
        (drive_volts >= VOLT_HIGH) |=> sw_q[2])
        else $error("high switch not chosen");
endmodule : range_decode

// [rtl/handler_if.sv]
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module handler_if
    import handler_pkg::*;
#(
    parameter int RESP_CYCLES    = RESP_CYC,
    parameter int ANALOG_CYCLES  = ANALOG_CYC,
    parameter int COMPUTE_CYCLES = COMPUTE_CYC
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Register port
    input  wire logic [3:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [15:0]              reg_rdata,
    // Handler pins
    input  wire logic                     external_trigger_in,
    input  wire logic                     lockout_n_in,
    output handler_pkg::handler_out_t     pins_out,
    // Range switches
    output logic                          range_switch_low,
    output logic                          range_switch_high,
    output logic                          range_switch_mid,
    // Interrupt
    output logic                          irq
);
    import handler_pkg::*;

    localparam int CW = 32;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] pins_sync;
    logic       trig_s;
    logic       lock_n_s;

    input_sync #(.W(2)) u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({lockout_n_in, external_trigger_in}),
        .sync_out (pins_sync)
    );
    assign trig_s   = pins_sync[0];
    assign lock_n_s = pins_sync[1];

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic               test_q, test_d;
    logic [5:0]         force_q, force_d;
    logic [3:0]         tclass_q, tclass_d;
    logic [2:0]         tcomp_q, tcomp_d;
    logic [4:0]         volt_q, volt_d;
    meas_result_t       res_q, res_d;
    logic [IRQ_W-1:0]   ien_q, ien_d;
    logic [IRQ_W-1:0]   ist_q, ist_d;
    logic [15:0]        rdata_q, rdata_d;
    logic               irq_q, irq_d;
    logic               start_sw;

    // ----------------------------------------
    // Measurement sequencer
    // ----------------------------------------
    meas_state_t        st_q, st_d;
    logic [CW-1:0]      cnt_q, cnt_d;
    logic [8:0]         trig_w_q, trig_w_d;
    logic               trig_acc;
    logic               acc_n_q, acc_n_d;
    logic               ana_n_q, ana_n_d;
    logic               cyc_n_q, cyc_n_d;
    logic               judg_ok_q, judg_ok_d;
    meas_result_t       held_q, held_d;
    handler_out_t       out_q, out_d;
    logic [IRQ_W-1:0]   ev;

    // Pulse must be held TRIG_MIN_CYC cycles; short glitches are ignored
    always_comb begin
        trig_w_d = trig_s ? ((trig_w_q == 9'(TRIG_MIN_CYC)) ? trig_w_q
                                                         : trig_w_q + 9'h1)
                          : 9'h0;
        trig_acc = (trig_w_q == 9'(TRIG_MIN_CYC - 1)) && trig_s;
    end

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        acc_n_d   = acc_n_q;
        ana_n_d   = ana_n_q;
        cyc_n_d   = cyc_n_q;
        judg_ok_d = judg_ok_q;
        held_d    = held_q;
        ev        = '0;
        case (st_q)
            ST_IDLE: begin
                // Only taken while accept is shown low
                if ((trig_acc || start_sw) && !acc_n_q) begin
                    st_d    = ST_RESP;
                    cnt_d   = CW'(RESP_CYCLES - 1);
                    ev[IRQ_TRIG_BIT] = 1'b1;
                end
            end
            ST_RESP: begin
                if (cnt_q == '0) begin
                    acc_n_d   = 1'b1;
                    ana_n_d   = 1'b1;
                    cyc_n_d   = 1'b1;
                    judg_ok_d = 1'b0;
                    st_d      = ST_ANALOG;
                    cnt_d     = CW'(ANALOG_CYCLES - 1);
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            ST_ANALOG: begin
                if (cnt_q == '0) begin
                    ana_n_d = 1'b0;
                    st_d    = ST_COMPUTE;
                    cnt_d   = CW'(COMPUTE_CYCLES - 1);
                    ev[IRQ_ANALOG_BIT] = 1'b1;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            ST_COMPUTE: begin
                if (cnt_q == '0) begin
                    held_d    = res_q;
                    judg_ok_d = 1'b1;
                    st_d      = ST_DONE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            ST_DONE: begin
                // Results latched one cycle before strobes move
                cyc_n_d = 1'b0;
                acc_n_d = 1'b0;
                st_d    = ST_IDLE;
                ev[IRQ_CYCLE_BIT] = 1'b1;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Output mux: measurement or forced values
    // ----------------------------------------
    logic [8:0] cls_meas;
    logic [8:0] cls_test;

    always_comb begin
        cls_meas = '1;
        cls_test = '1;
        if (held_q.sort_class >= 4'h1 && held_q.sort_class <= 4'h9) begin
            cls_meas[held_q.sort_class - 4'h1] = 1'b0;
        end
        if (tclass_q >= 4'h1 && tclass_q <= 4'h9) begin
            cls_test[tclass_q - 4'h1] = 1'b0;
        end
        if (test_q) begin
            out_d.fault_n            = force_q[TO_FAULT_BIT];
            out_d.analog_done_n      = force_q[TO_ANALOG_BIT];
            out_d.cycle_done_n       = force_q[TO_CYCLE_BIT];
            out_d.trigger_accept_n   = force_q[TO_ACCEPT_BIT];
            out_d.overrange_n        = force_q[TO_OVER_BIT];
            out_d.low_cap_or_open_n  = force_q[TO_OPEN_BIT];
            out_d.sort_class_n       = cls_test;
            out_d.primary_above_n    = ~tcomp_q[2];
            out_d.primary_below_n    = ~tcomp_q[1];
            out_d.secondary_reject_n = ~tcomp_q[0];
        end else begin
            out_d.fault_n            = 1'b1;
            out_d.analog_done_n      = ana_n_q;
            out_d.cycle_done_n       = cyc_n_q;
            out_d.trigger_accept_n   = acc_n_q;
            // Judgments held inactive while results are unsettled
            out_d.overrange_n        = ~(judg_ok_q & held_q.overrange);
            out_d.low_cap_or_open_n  = ~(judg_ok_q & held_q.low_cap);
            out_d.sort_class_n       = judg_ok_q ? cls_meas : '1;
            out_d.primary_above_n    = ~(judg_ok_q & held_q.comp[2]);
            out_d.primary_below_n    = ~(judg_ok_q & held_q.comp[1]);
            out_d.secondary_reject_n = ~(judg_ok_q & held_q.comp[0]);
        end
    end

    // ----------------------------------------
    // Register writes, reads and interrupts
    // ----------------------------------------
    always_comb begin
        test_d   = test_q;
        force_d  = force_q;
        tclass_d = tclass_q;
        tcomp_d  = tcomp_q;
        volt_d   = volt_q;
        res_d    = res_q;
        ien_d    = ien_q;
        start_sw = 1'b0;
        ist_d    = ist_q;
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    test_d   = reg_wdata[CTRL_TEST_BIT];
                    start_sw = reg_wdata[CTRL_START_BIT];
                end
                REG_TEST_OUT:   force_d  = reg_wdata[5:0];
                REG_TEST_CLASS: tclass_d = reg_wdata[3:0];
                REG_TEST_COMP:  tcomp_d  = reg_wdata[2:0];
                REG_VOLT:       volt_d   = reg_wdata[4:0];
                REG_INT_EN:     ien_d    = reg_wdata[IRQ_W-1:0];
                REG_INT_CLR:    ist_d    = ist_q & ~reg_wdata[IRQ_W-1:0];
                REG_MEAS_RES:   res_d    = reg_wdata[8:0];
                default: begin
                end
            endcase
        end
        // Set after clear so a coinciding event survives
        ist_d = ist_d | ev;
        irq_d = |(ist_d & ien_d);
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:       rdata_d = {15'h0000, test_q};
                REG_TEST_OUT:   rdata_d = {10'h000, force_q};
                REG_TEST_CLASS: rdata_d = {12'h000, tclass_q};
                REG_TEST_COMP:  rdata_d = {13'h0000, tcomp_q};
                REG_STATUS:     rdata_d = {10'h000, judg_ok_q, cyc_n_q,
                                           ana_n_q, acc_n_q, st_q[1:0]};
                // Levels read back only in test mode
                REG_INPUTS:     rdata_d = test_q ?
                                    {14'h0000, ~lock_n_s, trig_s}
                                    : 16'h0000;
                REG_VOLT:       rdata_d = {11'h000, volt_q};
                REG_INT_STAT:   rdata_d = {13'h0000, ist_q};
                REG_INT_EN:     rdata_d = {13'h0000, ien_q};
                REG_MEAS_RES:   rdata_d = {7'h00, res_q};
                REG_RANGE:      rdata_d = {13'h0000, range_switch_high,
                                           range_switch_mid,
                                           range_switch_low};
                default:        rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            test_q    <= 1'b0;
            force_q   <= 6'h3f;
            tclass_q  <= 4'h0;
            tcomp_q   <= 3'h0;
            volt_q    <= VOLT_RESET;
            res_q     <= '0;
            ien_q     <= '0;
            ist_q     <= '0;
            rdata_q   <= 16'h0000;
            irq_q     <= 1'b0;
            st_q      <= ST_IDLE;
            cnt_q     <= '0;
            trig_w_q  <= 9'h000;
            acc_n_q   <= 1'b0;
            ana_n_q   <= 1'b1;
            cyc_n_q   <= 1'b1;
            judg_ok_q <= 1'b0;
            held_q    <= '0;
            out_q     <= '1;
        end else begin
            test_q    <= test_d;
            force_q   <= force_d;
            tclass_q  <= tclass_d;
            tcomp_q   <= tcomp_d;
            volt_q    <= volt_d;
            res_q     <= res_d;
            ien_q     <= ien_d;
            ist_q     <= ist_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            trig_w_q  <= trig_w_d;
            acc_n_q   <= acc_n_d;
            ana_n_q   <= ana_n_d;
            cyc_n_q   <= cyc_n_d;
            judg_ok_q <= judg_ok_d;
            held_q    <= held_d;
            out_q     <= out_d;
        end
    end

    range_decode u_range (
        .mclk              (mclk),
        .reset             (reset),
        .drive_volts       (volt_q),
        .range_switch_low  (range_switch_low),
        .range_switch_mid  (range_switch_mid),
        .range_switch_high (range_switch_high)
    );

    assign pins_out  = out_q;
    assign reg_rdata = rdata_q;
    assign irq       = irq_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_trig_min_width: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_IDLE && st_d == ST_RESP && !start_sw)
        |-> trig_w_q == 9'(TRIG_MIN_CYC - 1)) else $error("short trigger");
    a_resp_delay: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_RESP && cnt_q == '0) |=> acc_n_q && ana_n_q && cyc_n_q)
        else $error("strobes not updated");
    a_ready_after: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_DONE) |=> !acc_n_q && st_q == ST_IDLE)
        else $error("no ready after cycle");
    a_analog_end: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_ANALOG && cnt_q == '0) |=> !ana_n_q && cyc_n_q)
        else $error("analog done wrong");
    a_cycle_valid: assert property (@(posedge mclk) disable iff (reset)
        $fell(cyc_n_q) |-> judg_ok_q) else $error("cycle done early");
    a_test_force: assert property (@(posedge mclk) disable iff (reset)
        test_q |=> out_q.fault_n == $past(force_q[TO_FAULT_BIT])
                && out_q.overrange_n == $past(force_q[TO_OVER_BIT]))
        else $error("forced value missing");
    a_test_comp: assert property (@(posedge mclk) disable iff (reset)
        test_q |=> out_q.primary_above_n == !$past(tcomp_q[2]))
        else $error("comparator not driven");
    a_norm_restore: assert property (@(posedge mclk) disable iff (reset)
        !test_q |=> out_q.cycle_done_n == $past(cyc_n_q)
                 && out_q.fault_n)
        else $error("measurement outputs not restored");
    a_input_read: assert property (@(posedge mclk) disable iff (reset)
        (reg_rd && reg_addr == REG_INPUTS && test_q)
        |=> reg_rdata[0] == $past(trig_s)) else $error("trigger read bad");
    c_full_cycle: cover property (@(posedge mclk) st_q == ST_DONE);
    c_test_mode: cover property (@(posedge mclk) $rose(test_q));
    c_irq: cover property (@(posedge mclk) $rose(irq_q));
endmodule : handler_if

// [dv/handler_model.sv]
`timescale 1ns/1ns
module handler_model
    import handler_pkg::*;
#(
    parameter int PULSE_CYC = 24
) (
    // Clock
    input  wire logic                      mclk,
    // Bench controls
    input  wire logic                      fire,
    input  wire logic                      hold,
    input  wire logic                      locked,
    // Meter pins
    input  wire handler_pkg::handler_out_t pins_in,
    output logic                           external_trigger_in,
    output logic                           lockout_n_in
);
    // ----------------------------------------
    // Trigger pulse generator
    // ----------------------------------------
    int   cnt  = 0;
    logic pend = 1'b0;
    // Pulse is stretched past the minimum so synchroniser lag cannot eat it
    always @(posedge mclk) begin
        if (fire)
            pend <= 1'b1;
        if (pend && cnt == 0 && pins_in.trigger_accept_n === 1'b0) begin
            pend <= 1'b0;
            cnt  <= PULSE_CYC;
        end else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign external_trigger_in = hold | (cnt != 0);
    assign lockout_n_in        = ~locked;
endmodule : handler_model

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import handler_pkg::*;
    logic         mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
    logic [3:0]   reg_addr = '0;
    logic [15:0]  reg_wdata = '0, reg_rdata, v;
    logic         fire = 0, hold = 0, locked = 0, irq;
    logic         external_trigger_in, lockout_n_in;
    logic         range_switch_low, range_switch_mid, range_switch_high;
    handler_out_t pins_out;
    meas_result_t res;
    int           fails = 0, checked = 0, cycles = 0, seed = 51, t;
    int           bnd[6] = '{5, 8, 9, 14, 15, 24};

    handler_if #(.RESP_CYCLES(4), .ANALOG_CYCLES(8), .COMPUTE_CYCLES(6))
        u_handler_if (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .external_trigger_in, .lockout_n_in,
        .pins_out, .range_switch_low, .range_switch_high,
        .range_switch_mid, .irq);
    handler_model u_handler_model (.mclk, .fire, .hold, .locked,
        .pins_in(pins_out), .external_trigger_in, .lockout_n_in);

    // ----------------------------------------
    // Shared tasks and expectations
    // ----------------------------------------
    task automatic chk(input string what, input logic [17:0] e,
                       input logic [17:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic wait_pin(input int b, input logic lvl);
        t = 0;
        while (pins_out[b] !== lvl && t < 60) begin
            tick(1);
            t++;
        end
    endtask : wait_pin
    function automatic handler_out_t pins_of(input logic [5:0] o,
        input logic [3:0] c, input logic [2:0] cmp);
        handler_out_t p;
        {p.low_cap_or_open_n, p.overrange_n, p.trigger_accept_n,
         p.cycle_done_n, p.analog_done_n, p.fault_n} = o;
        for (int i = 0; i < 9; i++)
            p.sort_class_n[i] = (c != 4'(i + 1));
        {p.primary_above_n, p.primary_below_n, p.secondary_reject_n} = ~cmp;
        return p;
    endfunction : pins_of
    function automatic logic [2:0] rng_of(input int x);
        return (x < 9) ? 3'b001 : (x < 15) ? 3'b010 : 3'b100;
    endfunction : rng_of
    // Trigger through the handler model, then follow the handshake
    task automatic measure();
        res = 9'($random(seed));
        wr(REG_MEAS_RES, 16'(res));
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        wait_pin(14, 1'b1);
        chk("resp_time", 1, t >= 24 && t <= 34);
        chk("strobes_high", 3'b111, pins_out[16:14]);
        wait_pin(16, 1'b0);
        chk("analog_phase", 18'h2ffff, pins_out);
        wait_pin(15, 1'b0);
        chk("cycle_end", pins_of({~res.low_cap, ~res.overrange, 4'h1},
            res.sort_class, res.comp), pins_out);
    endtask : measure
    task automatic complete_run();
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        tick(3);
        chk("reset_pins", 18'h3bfff, pins_out);
        chk("reset_irq", 0, irq);
        rd(REG_VOLT);
        chk("volt_reset", VOLT_RESET, v);
        for (int n = 0; n < 12; n++) begin
            t = (n < 6) ? bnd[n] : 5 + ($unsigned($random(seed)) % 20);
            wr(REG_VOLT, 16'(t));
            tick(3);
            chk("range", rng_of(t), {range_switch_high, range_switch_mid,
                range_switch_low});
        end
        wr(REG_INT_EN, 16'h0007);
        measure();
        measure();
        chk("irq_set", 1, irq);
        rd(REG_INT_STAT);
        chk("int_stat", 3'b111, v[2:0]);
        wr(REG_INT_CLR, 16'h0007);
        tick(2);
        chk("irq_clear", 0, irq);
        wr(REG_INT_EN, 16'h0000);
        measure();
        chk("irq_masked", 0, irq);
        rd(REG_INPUTS);
        chk("inputs_off", 0, v);
        rd(4'hf);
        chk("unmapped", 0, v);
        wr(REG_CTRL, 16'h0001);
        for (int c = 1; c <= 9; c++) begin
            t = $random(seed);
            wr(REG_TEST_CLASS, 16'(c));
            wr(REG_TEST_COMP, 16'(t[2:0]));
            wr(REG_TEST_OUT, 16'(t[8:3]));
            tick(2);
            chk("test_pins", pins_of(t[8:3], 4'(c), t[2:0]), pins_out);
        end
        hold   <= 1'b1;
        locked <= 1'b1;
        tick(4);
        rd(REG_INPUTS);
        chk("inputs_high", 2'b11, v[1:0]);
        hold   <= 1'b0;
        locked <= 1'b0;
        tick(4);
        rd(REG_INPUTS);
        chk("inputs_low", 2'b00, v[1:0]);
        wr(REG_CTRL, 16'h0000);
        tick(3);
        chk("exit_test", pins_of({~res.low_cap, ~res.overrange, 4'h1},
            res.sort_class, res.comp), pins_out);
        complete_run();
    end
endmodule : testbench
